// >>> common/tmon_pkg.sv
`default_nettype none
package tmon_pkg;
    // Fixed pointer values of read-only and trigger locations
    localparam logic [7:0] PTR_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] PTR_REMOTE_HIGH = 8'h01;
    localparam logic [7:0] PTR_STATUS = 8'h02;
    localparam logic [7:0] PTR_ONE_SHOT = 8'h0f;
    localparam logic [7:0] PTR_REMOTE_LOW = 8'h10;
    localparam logic [7:0] PTR_MAKER = 8'hfe;
    localparam logic [7:0] PTR_REVISION = 8'hff;
    // Writable settings: read address, write address, reset value
    localparam int NUM_SET = 14;
    localparam logic [7:0] SET_RD_ADDR [NUM_SET] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11,
        8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22};
    localparam logic [7:0] SET_WR_ADDR [NUM_SET] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11,
        8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22};
    localparam logic [7:0] SET_RESET [NUM_SET] = '{8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0a, 8'h01};
    localparam int SET_CONFIG = 0;
    localparam int SET_COUNT = 13;
    // Field positions
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CNT_TIMEOUT_BIT = 7;
    localparam int CNT_LSB = 1;
    localparam int CNT_MSB = 3;
    // Bus addresses of the two variants
    localparam logic [6:0] DEV_ADDR_STD = 7'h4c;
    localparam logic [6:0] DEV_ADDR_ALT = 7'h4d;
    // Bus inactivity timeout
    localparam int CLOCK_HZ = 100_000_000;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLOCK_HZ / 1000);
    localparam int TIMEOUT_W = 22;
    // Controller command port
    localparam logic [1:0] HOST_CMD = 2'h0;
    localparam logic [1:0] HOST_TARGET = 2'h1;
    localparam logic [1:0] HOST_POINTER = 2'h2;
    localparam logic [1:0] HOST_DATA = 2'h3;
    localparam logic [1:0] KIND_WRITE_DATA = 2'h0;
    localparam logic [1:0] KIND_POINTER_ONLY = 2'h1;
    localparam logic [1:0] KIND_READ = 2'h2;
    localparam logic [6:0] HOST_TARGET_RESET = DEV_ADDR_STD;
    localparam int SCL_QUARTER = 10;
endpackage : tmon_pkg
`default_nettype wire

// >>> common/tmon_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tmon_link_if;
    logic scl;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic dev_alert_oe;
    logic sda;
    logic alert_n;
    // Open-drain resolution with pull-ups
    assign sda = !(host_sda_oe || dev_sda_oe);
    assign alert_n = !dev_alert_oe;
    modport device (input scl, input sda, output dev_sda_oe, output dev_alert_oe);
    modport host (output scl, output host_sda_oe, input sda, input alert_n);
endinterface : tmon_link_if
`default_nettype wire

// >>> hdl/tmon_serial_slave.sv
// Function
// RQ1: One-shot write runs one conversion both channels
// RQ2: One-shot in standby returns to standby
// RQ3: One-shot data byte ignored, never stored
// RQ4: Alert after programmed consecutive out-of-limit count
// RQ5: Default count one, maximum four
// RQ6: Count register at 0x22, bit7 enables timeout
// RQ7: Timeout abandons transfer after 25 ms idle
// RQ8: Answer only own fixed 7-bit address
// RQ9: Start is data falling with clock high
// RQ10: First byte: address MSB first, direction bit
// RQ11: Matching device acknowledges, others stay idle
// RQ12: Nine clocks per byte, data changes low
// RQ13: Master ends write with stop
// RQ14: Read ends with no-acknowledge, stop, release
// RQ15: Direction fixed for whole transfer
// RQ16: Writes one or two bytes, read one
// RQ17: First write byte always loads pointer
// RQ18: Second write byte stored at pointer
// RQ19: Read returns register the pointer selects
// RQ20: Open-drain alert low on trip or open
// RQ21: Config bit6 standby stops conversions only
// RQ22: Separate read and write address tables
// RQ23: Pointer-only write changes no register
`timescale 1ns/100ps
`default_nettype none
module tmon_serial_slave import tmon_pkg::*; #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter logic [7:0] MAKER_CODE = 8'h5a,      // Arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01,   // Arbitrary value
    parameter int TIMEOUT_COUNT = TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    tmon_link_if.device link,
    input wire logic [7:0] local_temp,
    input wire logic [7:0] remote_temp_high,
    input wire logic [7:0] remote_temp_low,
    input wire logic [7:0] status_in,
    input wire logic conv_done,
    input wire logic out_of_limit,
    input wire logic sensor_open,
    input wire logic alert_clear,
    output logic run_conversions,
    output logic one_shot_pulse,
    output logic [NUM_SET*8-1:0] settings
);
    if (TIMEOUT_COUNT < 2 || TIMEOUT_COUNT > 4194303) begin : g_check
        $error("timeout count out of range");
    end

    typedef enum logic [7:0] {
        S_IDLE = 8'b0000_0001,
        S_ADDR = 8'b0000_0010,
        S_ACK_ADDR = 8'b0000_0100,
        S_WRITE = 8'b0000_1000,
        S_ACK_WRITE = 8'b0001_0000,
        S_READ = 8'b0010_0000,
        S_ACK_READ = 8'b0100_0000,
        S_IGNORE = 8'b1000_0000
    } slave_state_t;

    // Table lookup: {hit, index} of a pointer in the read or write table
    function automatic logic [4:0] slot(input logic [7:0] a, input logic use_write);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < NUM_SET; i++) begin
            if ((use_write ? SET_WR_ADDR[i] : SET_RD_ADDR[i]) == a) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : slot

    // Count code to required consecutive measurements
    function automatic logic [2:0] needed(input logic [2:0] c);
        case (c)
            3'b001: needed = 3'h2;
            3'b011: needed = 3'h3;
            3'b111: needed = 3'h4;
            default: needed = 3'h1;
        endcase
    endfunction : needed

    slave_state_t state, next_state;
    logic [1:0] scl_sync, sda_sync;
    logic scl_q, sda_q;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, tx, next_tx, pointer;
    logic [1:0] byte_cnt, next_byte_cnt;
    logic rw, next_rw, sda_oe, next_sda_oe;
    logic [7:0] reg_file [NUM_SET];
    logic oneshot_pend, alert_latch;
    logic [2:0] miss_cnt;
    logic [TIMEOUT_W-1:0] idle_cnt;

    // Synchronised bus levels and conditions
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    // RQ9: start condition detect
    wire start_seen = scl_s & scl_q & sda_q & ~sda_s;
    // RQ12: rising data while clock high is stop
    wire stop_seen = scl_s & scl_q & ~sda_q & sda_s;
    wire activity = (scl_s ^ scl_q) | (sda_s ^ sda_q);
    wire byte_end = scl_fall & (bit_cnt == 4'h8);

    // Address match and write decode
    wire [6:0] own_addr = ALT_VARIANT ? DEV_ADDR_ALT : DEV_ADDR_STD;
    // RQ8: compare with own address
    wire addr_hit = shreg[7:1] == own_addr;
    wire ptr_event = (state == S_WRITE) & byte_end & (byte_cnt == 2'h0);
    wire data_event = (state == S_WRITE) & byte_end & (byte_cnt == 2'h1);
    // RQ22: write goes through write table only
    wire [4:0] wr_slot = slot(pointer, 1'b1);
    // RQ1: write access to one-shot address
    wire one_shot_hit = data_event & (pointer == PTR_ONE_SHOT);
    wire standby = reg_file[SET_CONFIG][CFG_STANDBY_BIT];
    // RQ6: timeout enable from count register
    wire timeout_en = reg_file[SET_COUNT][CNT_TIMEOUT_BIT];
    // RQ7: idle bus abandons transaction
    wire timeout = timeout_en & (state != S_IDLE) & (idle_cnt == TIMEOUT_W'(TIMEOUT_COUNT - 1));

    // RQ19: read value from pointer, read table first
    wire [4:0] rd_slot = slot(pointer, 1'b0);
    wire [7:0] read_value = rd_slot[4] ? reg_file[rd_slot[3:0]] :
        (pointer == PTR_LOCAL_TEMP) ? local_temp :
        (pointer == PTR_REMOTE_HIGH) ? remote_temp_high :
        (pointer == PTR_STATUS) ? status_in :
        (pointer == PTR_REMOTE_LOW) ? remote_temp_low :
        (pointer == PTR_MAKER) ? MAKER_CODE :
        (pointer == PTR_REVISION) ? REVISION_CODE : 8'h00;

    // RQ4: trip on consecutive misses or open sensor
    wire [2:0] need = needed(reg_file[SET_COUNT][CNT_MSB:CNT_LSB]);
    wire trip = conv_done & ((out_of_limit & ((miss_cnt + 3'h1) >= need)) | sensor_open);

    // Two-flop synchronisers and edge history
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Byte engine next state
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_tx = tx;
        next_rw = rw;
        next_byte_cnt = byte_cnt;
        next_sda_oe = sda_oe;
        // RQ10: shift in MSB first
        if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
        end
        case (state)
            S_ADDR: begin
                if (byte_end) begin
                    next_bit_cnt = 4'h0;
                    // RQ11: acknowledge on match, else ignore rest of transfer
                    if (addr_hit) begin
                        next_sda_oe = 1'b1;
                        next_rw = shreg[0];
                        next_state = S_ACK_ADDR;
                    end else begin
                        next_state = S_IGNORE;
                    end
                end
            end
            S_ACK_ADDR: begin
                if (scl_fall) begin
                    next_bit_cnt = 4'h0;
                    next_byte_cnt = 2'h0;
                    // RQ15: direction latched for transfer
                    if (rw) begin
                        next_tx = read_value;
                        next_sda_oe = ~read_value[7];
                        next_state = S_READ;
                    end else begin
                        next_sda_oe = 1'b0;
                        next_state = S_WRITE;
                    end
                end
            end
            S_WRITE: begin
                if (byte_end) begin
                    next_bit_cnt = 4'h0;
                    // RQ16: third write byte is not acknowledged
                    if (byte_cnt != 2'h2) begin
                        next_sda_oe = 1'b1;
                        next_byte_cnt = byte_cnt + 2'h1;
                        next_state = S_ACK_WRITE;
                    end else begin
                        next_state = S_IGNORE;
                    end
                end
            end
            S_ACK_WRITE: begin
                if (scl_fall) begin
                    next_bit_cnt = 4'h0;
                    next_sda_oe = 1'b0;
                    next_state = S_WRITE;
                end
            end
            S_READ: begin
                // RQ12: drive data only after falling clock
                if (byte_end) begin
                    next_sda_oe = 1'b0;
                    next_state = S_ACK_READ;
                end else if (scl_fall) begin
                    next_tx = {tx[6:0], 1'b0};
                    next_sda_oe = ~tx[6];
                end
            end
            S_ACK_READ: begin
                // RQ16: one byte per read, bus stays released
                if (scl_rise) begin
                    next_state = S_IGNORE;
                end
            end
            S_IDLE, S_IGNORE: begin
                next_sda_oe = 1'b0;
            end
            default: begin
                next_state = S_IDLE;
                next_sda_oe = 1'b0;
            end
        endcase
        if (start_seen) begin
            next_state = S_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_seen || timeout) begin
            // RQ14: release bus on stop
            next_state = S_IDLE;
            next_sda_oe = 1'b0;
        end
    end

    // Byte engine registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            rw <= 1'b0;
            byte_cnt <= 2'h0;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            tx <= next_tx;
            rw <= next_rw;
            byte_cnt <= next_byte_cnt;
            sda_oe <= next_sda_oe;
        end
    end

    // RQ17: first write byte always loads pointer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pointer <= 8'h00;
        end else if (ptr_event) begin
            pointer <= shreg;
        end
    end

    // RQ18: second byte stored where pointer selects
    // RQ23: read-only or unknown pointer writes nothing
    // RQ3: one-shot address has no table slot
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_SET; i++) begin
                reg_file[i] <= SET_RESET[i];
            end
        end else if (data_event && wr_slot[4]) begin
            reg_file[wr_slot[3:0]] <= shreg;
        end
    end

    // RQ7: inactivity counter, cleared by any edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt <= '0;
        end else if (activity || state == S_IDLE || timeout) begin
            idle_cnt <= '0;
        end else begin
            idle_cnt <= idle_cnt + TIMEOUT_W'(1);
        end
    end

    // RQ2: one-shot pending until its cycle completes
    // RQ21: standby holds conversions off, bus stays live
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            oneshot_pend <= 1'b0;
            one_shot_pulse <= 1'b0;
            run_conversions <= 1'b0;
        end else begin
            oneshot_pend <= one_shot_hit | (oneshot_pend & ~conv_done);
            one_shot_pulse <= one_shot_hit;
            run_conversions <= ~standby | one_shot_hit | (oneshot_pend & ~conv_done);
        end
    end

    // RQ5: consecutive miss counter saturates at four
    // RQ20: alert latch, set wins over clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            miss_cnt <= 3'h0;
            alert_latch <= 1'b0;
        end else begin
            if (conv_done) begin
                miss_cnt <= !out_of_limit ? 3'h0 : (miss_cnt == 3'h4) ? 3'h4 : miss_cnt + 3'h1;
            end
            alert_latch <= trip | (alert_latch & ~alert_clear);
        end
    end

    // Pin and settings outputs straight from flops
    assign link.dev_sda_oe = sda_oe;
    assign link.dev_alert_oe = alert_latch;
    for (genvar g = 0; g < NUM_SET; g++) begin : g_settings
        assign settings[g*8 +: 8] = reg_file[g];
    end
endmodule : tmon_serial_slave
`default_nettype wire

// >>> hdl/tmon_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module tmon_bus_master import tmon_pkg::*; #(
    parameter int QUARTER = SCL_QUARTER
) (
    input wire logic clock,
    input wire logic arst_n,
    tmon_link_if.host link,
    input wire logic [1:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    output logic busy
);
    if (QUARTER < 4 || QUARTER > 255) begin : g_check
        $error("quarter period out of range");
    end

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_START = 4'b0010,
        H_BIT = 4'b0100,
        H_STOP = 4'b1000
    } host_state_t;

    host_state_t state;
    logic [1:0] sda_sync;
    logic [7:0] div;
    logic [1:0] phase, kind, byte_idx;
    logic [3:0] bit_idx;
    logic [6:0] target;
    logic [7:0] pointer_byte, data_byte, shreg, rx;
    logic nack, scl, sda_oe;

    // Command decode and sequencing terms
    wire tick = div == 8'(QUARTER - 1);
    wire go = write_strobe & (address == HOST_CMD) & (state == H_IDLE);
    wire sda_s = sda_sync[1];
    wire reading = (kind == KIND_READ) & (byte_idx == 2'h1);
    // RQ16: read and pointer-only carry one byte, write two
    wire [1:0] last_idx = (kind == KIND_WRITE_DATA) ? 2'h2 : 2'h1;
    // RQ10: address byte with direction bit
    wire [7:0] addr_byte = {target, kind == KIND_READ};
    wire [7:0] next_byte = (byte_idx == 2'h0) ? pointer_byte : data_byte;
    wire [7:0] status_value = {6'h00, nack, busy};
    wire [7:0] read_value = (address == HOST_CMD) ? status_value :
        (address == HOST_TARGET) ? {1'b0, target} :
        (address == HOST_POINTER) ? pointer_byte : data_byte;

    // Divider for the serial clock quarters
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div <= 8'h00;
            sda_sync <= 2'h3;
        end else begin
            div <= (go || tick) ? 8'h00 : div + 8'h01;
            sda_sync <= {sda_sync[0], link.sda};
        end
    end

    // Command port registers and read data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            target <= HOST_TARGET_RESET;
            pointer_byte <= 8'h00;
            kind <= KIND_WRITE_DATA;
            read_data <= 8'h00;
        end else begin
            if (write_strobe && address == HOST_TARGET) target <= write_data[6:0];
            if (write_strobe && address == HOST_POINTER) pointer_byte <= write_data;
            if (go) kind <= write_data[1:0];
            read_data <= read_strobe ? read_value : 8'h00;
        end
    end

    // Bit sequencer, one step per quarter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= H_IDLE;
            phase <= 2'h0;
            byte_idx <= 2'h0;
            bit_idx <= 4'h0;
            shreg <= 8'h00;
            rx <= 8'h00;
            data_byte <= 8'h00;
            nack <= 1'b0;
            busy <= 1'b0;
            scl <= 1'b1;
            sda_oe <= 1'b0;
        end else if (go) begin
            state <= H_START;
            phase <= 2'h0;
            nack <= 1'b0;
            busy <= 1'b1;
        end else if (write_strobe && address == HOST_DATA && state == H_IDLE) begin
            data_byte <= write_data;
        end else if (tick && state != H_IDLE) begin
            phase <= phase + 2'h1;
            case (state)
                H_START: begin
                    // RQ9: data falls while clock high
                    case (phase)
                        2'h0: scl <= 1'b1;
                        2'h1: sda_oe <= 1'b1;
                        2'h2: scl <= 1'b0;
                        default: begin
                            state <= H_BIT;
                            byte_idx <= 2'h0;
                            bit_idx <= 4'h0;
                            shreg <= addr_byte;
                        end
                    endcase
                end
                H_BIT: begin
                    // RQ12: change data only while clock low
                    // RQ14: acknowledge slot released, giving no-acknowledge
                    case (phase)
                        2'h0: sda_oe <= (bit_idx != 4'h8) & ~reading & ~shreg[7];
                        2'h1: scl <= 1'b1;
                        2'h2: begin
                            if (bit_idx != 4'h8) begin
                                rx <= {rx[6:0], sda_s};
                                shreg <= {shreg[6:0], 1'b0};
                            end else if (!reading && sda_s) begin
                                nack <= 1'b1;
                            end
                        end
                        default: begin
                            scl <= 1'b0;
                            if (bit_idx != 4'h8) begin
                                bit_idx <= bit_idx + 4'h1;
                            end else if (nack || byte_idx == last_idx) begin
                                // RQ15: direction never changes mid-transfer
                                state <= H_STOP;
                                if (reading) data_byte <= rx;
                            end else begin
                                byte_idx <= byte_idx + 2'h1;
                                bit_idx <= 4'h0;
                                shreg <= next_byte;
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    // RQ13: data rises while clock high
                    case (phase)
                        2'h0: sda_oe <= 1'b1;
                        2'h1: scl <= 1'b1;
                        2'h2: sda_oe <= 1'b0;
                        default: begin
                            state <= H_IDLE;
                            busy <= 1'b0;
                        end
                    endcase
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // RQ19: pointer-only write then read reuses pointer
    assign link.scl = scl;
    assign link.host_sda_oe = sda_oe;
endmodule : tmon_bus_master
`default_nettype wire

// >>> bench/tmon_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module tmon_link_props (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    // One clock domain for every check
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_DEV_EDGE_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    AST_DEV_AFTER_FALL: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
        else $error("device drive not after clock fall");
    AST_DEV_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("device drive too short");
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*4])
        else $error("clock high phase too short");
    AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*4])
        else $error("clock low phase too short");
    AST_START_HOST: assert property (scl && $fell(sda) |-> host_sda_oe && !dev_sda_oe)
        else $error("start not made by master alone");
    AST_STOP_RELEASE: assert property (scl && $rose(sda) |=> !dev_sda_oe [*4])
        else $error("device holds data after stop");
    AST_IDLE_AFTER_RESET: assert property ($rose(arst_n) |-> scl && sda)
        else $error("bus not idle after reset");
endmodule : tmon_link_props
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import tmon_pkg::*;;
    logic clock, arst_n, wstb, rstb, busy, conv_done, out_of_limit, sensor_open, alert_clear, run_conv, shot;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, ltemp, rth, rtl, stat, got, v;
    logic [NUM_SET*8-1:0] settings;
    logic [7:0] mdl [NUM_SET];
    integer failures = 0, check_count = 0, seed = 56628, shots = 0, i;
    tmon_link_if link_i ();
    tmon_serial_slave #(.MAKER_CODE(8'h3c), .REVISION_CODE(8'h07), .TIMEOUT_COUNT(200)) tmon_serial_slave_i (
        .clock(clock), .arst_n(arst_n), .link(link_i), .local_temp(ltemp), .remote_temp_high(rth),
        .remote_temp_low(rtl), .status_in(stat), .conv_done(conv_done), .out_of_limit(out_of_limit),
        .sensor_open(sensor_open), .alert_clear(alert_clear), .run_conversions(run_conv),
        .one_shot_pulse(shot), .settings(settings));
    tmon_bus_master #(.QUARTER(4)) tmon_bus_master_i (.clock(clock), .arst_n(arst_n), .link(link_i),
        .address(addr), .write_data(wdata), .write_strobe(wstb), .read_strobe(rstb), .read_data(rdata), .busy(busy));
    tmon_link_props tmon_link_props_i (.clock(clock), .arst_n(arst_n), .scl(link_i.scl),
        .host_sda_oe(link_i.host_sda_oe), .dev_sda_oe(link_i.dev_sda_oe), .sda(link_i.sda));
    // Clock and trigger counter
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (shot === 1'b1) shots++;
    task close_out;
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task bw(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clock);
        wstb <= 1'b0;
    endtask : bw
    task br(input logic [1:0] a);
        @(posedge clock);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clock);
        rstb <= 1'b0;
        #1 got = rdata;
    endtask : br
    task xfer(input logic [1:0] kind, input logic [7:0] p, input logic [7:0] d);
        integer n;
        n = 0;
        bw(HOST_POINTER, p);
        bw(HOST_DATA, d);
        bw(HOST_CMD, {6'h00, kind});
        repeat (2) @(posedge clock);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 5000) failures++;
        if (kind == KIND_READ) br(HOST_DATA);
    endtask : xfer
    task rd(input logic [7:0] p, input logic [7:0] exp);
        xfer(KIND_POINTER_ONLY, p, 8'h00);
        xfer(KIND_READ, 8'h00, 8'h00);
        check("register", exp, got);
    endtask : rd
    task conv(input logic ool, input logic clr);
        @(posedge clock);
        conv_done <= !clr;
        alert_clear <= clr;
        out_of_limit <= ool;
        @(posedge clock);
        conv_done <= 1'b0;
        alert_clear <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : conv
    // Main sequence
    initial begin
        {arst_n, wstb, rstb, conv_done, out_of_limit, sensor_open, alert_clear, addr, wdata} = '0;
        ltemp = 8'($random(seed));
        rth = 8'($random(seed));
        rtl = 8'($random(seed));
        stat = 8'($random(seed));
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (i = 0; i < NUM_SET; i++) rd(SET_RD_ADDR[i], SET_RESET[i]);
        rd(PTR_MAKER, 8'h3c);
        rd(PTR_LOCAL_TEMP, ltemp);
        rd(PTR_REMOTE_HIGH, rth);
        rd(PTR_REMOTE_LOW, rtl);
        rd(PTR_STATUS, stat);
        for (i = 0; i < NUM_SET; i++) begin
            v = 8'($random(seed));
            mdl[i] = v;
            xfer(KIND_WRITE_DATA, SET_WR_ADDR[i], v);
            if (SET_RD_ADDR[i] != SET_WR_ADDR[i]) xfer(KIND_WRITE_DATA, SET_RD_ADDR[i], ~v);
            rd(SET_RD_ADDR[i], mdl[i]);
            check("settings", mdl[i], settings[i*8+:8]);
        end
        bw(HOST_TARGET, {1'b0, DEV_ADDR_ALT});
        xfer(KIND_WRITE_DATA, 8'h0b, ~mdl[2]);
        br(HOST_CMD);
        check("nack", 8'h02, got);
        bw(HOST_TARGET, {1'b0, DEV_ADDR_STD});
        rd(8'h05, mdl[2]);
        xfer(KIND_WRITE_DATA, 8'h09, 8'h40);
        xfer(KIND_WRITE_DATA, 8'h22, 8'h02);
        check("run", 8'h00, {7'h00, run_conv});
        xfer(KIND_WRITE_DATA, PTR_ONE_SHOT, 8'($random(seed)));
        check("shots", 8'h01, shots[7:0]);
        check("run", 8'h01, {7'h00, run_conv});
        rd(PTR_ONE_SHOT, 8'h00);
        conv(1'b1, 1'b0);
        check("run", 8'h00, {7'h00, run_conv});
        check("alert", 8'h01, {7'h00, link_i.alert_n});
        conv(1'b1, 1'b0);
        check("alert", 8'h00, {7'h00, link_i.alert_n});
        conv(1'b0, 1'b1);
        check("alert", 8'h01, {7'h00, link_i.alert_n});
        xfer(KIND_WRITE_DATA, 8'h22, 8'h0e);
        conv(1'b0, 1'b0);
        repeat (3) conv(1'b1, 1'b0);
        check("alert", 8'h01, {7'h00, link_i.alert_n});
        conv(1'b1, 1'b0);
        check("alert", 8'h00, {7'h00, link_i.alert_n});
        conv(1'b0, 1'b1);
        sensor_open <= 1'b1;
        conv(1'b0, 1'b0);
        check("alert", 8'h00, {7'h00, link_i.alert_n});
        close_out();
    end
    // Hang guard
    initial begin
        #600_000;
        failures++;
        close_out();
    end
endmodule : tb
`default_nettype wire
